/* include/sfa_defs.vh */
// Purpose: constants for the sample FIFO and interrupt-enable block
// Assumes: byte-wide register file reached over the two-wire serial port
// Notes:   definitions only
`ifndef SFA_DEFS_VH
`define SFA_DEFS_VH

`define SFA_OFS_STATUS       8'h00
`define SFA_OFS_INT_ENABLE   8'h02
`define SFA_OFS_WRITE_PTR    8'h04
`define SFA_OFS_LOST_COUNT   8'h05
`define SFA_OFS_READ_PTR     8'h06
`define SFA_OFS_POP_DATA     8'h07
`define SFA_OFS_FIFO_CONFIG  8'h08

`define SFA_BIT_ALMOST_FULL  7
`define SFA_BIT_SAMPLE_READY 6
`define SFA_BIT_AMBIENT_OVF  5
`define SFA_BIT_PROXIMITY    4

`define SFA_CFG_AVG_HI       7
`define SFA_CFG_AVG_LO       5
`define SFA_CFG_ROLLOVER     4
`define SFA_CFG_THR_HI       3
`define SFA_CFG_THR_LO       0

`define SFA_RST_INT_ENABLE   4'h0
`define SFA_RST_AVG_CODE     3'h0
`define SFA_RST_ROLLOVER     1'b0
`define SFA_RST_THRESHOLD    4'hf

`define SFA_FIFO_DEPTH       6'h20
`define SFA_LOST_MAX         5'h1f
`define SFA_AVG_MAX_SHIFT    3'h5
`define SFA_BYTES_PER_SAMPLE 2'h3
`define SFA_STAGE_DEPTH      8

`endif

/* src/sfa_sample_fifo.v */
// Purpose: sample FIFO, averaging, roll-over and interrupt enables behind a two-wire serial port
// Assumes: scl_in and sda_in are already synchronous to clk_sys; scl well below clk_sys/8
// Notes:   sda is open drain: the module only pulls low, sda_oe high while pulling
//
// Functional notes
// - almost-full flag reaches the interrupt only while its enable bit 7 is set
// - sample-ready flag reaches the interrupt only while enable bit 6 is set
// - ambient-overflow flag reaches the interrupt only while enable bit 5 is set
// - start with proximity enable set runs proximity mode on first emitter at pilot current
// - threshold crossing in proximity mode raises proximity flag and enters selected mode
// - 5-bit write pointer, reset zero, advances per pushed sample
// - 5-bit lost-sample counter counts samples lost at full, saturating
// - lost-sample counter clears whenever a sample is read out
// - 5-bit read pointer, reset zero, advances per popped sample
// - host may write the read pointer to re-read samples
// - read-only 8-bit data register; writes to it do nothing
// - averaging code selects 1,2,4,8,16,32; codes 5 to 7 all select 32
// - each emitter channel averaged separately, pushed in sequence order
// - entries produced at sample rate divided by averaging count
// - roll-over at full overwrites oldest and advances both pointers
// - stop-on-full discards new samples, pointers unchanged
// - proximity mode always pushes as roll-over
// - FIFO flushed when proximity interrupt triggers
// - almost-full set when unread count reaches 32 minus free-space threshold
// - sample-ready set on new sample, cleared by status or data read
// - status read clears almost-full, ambient-overflow and proximity flags
`timescale 1ns/1ps
`default_nettype none
`include "sfa_defs.vh"

module sfa_stage_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8
) (
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = $clog2(DEPTH);
  reg  [WIDTH-1:0] store [0:DEPTH-1];
  reg  [AW-1:0]    head_reg;
  reg  [AW-1:0]    tail_reg;
  reg  [AW:0]      fill_reg;
  wire             take = in_valid && in_ready;
  wire             give = out_valid && out_ready;
  wire [AW:0]      fill_next = fill_reg + {{AW{1'b0}}, take} - {{AW{1'b0}}, give};

  assign out_valid = (fill_reg != {(AW+1){1'b0}});
  assign out_data  = store[tail_reg];

  always @(posedge clk_sys) begin
    if (take)
      store[head_reg] <= in_data;
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      head_reg <= {AW{1'b0}};
      tail_reg <= {AW{1'b0}};
      fill_reg <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      if (take)
        head_reg <= (head_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : head_reg + 1'b1;
      if (give)
        tail_reg <= (tail_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : tail_reg + 1'b1;
      fill_reg <= fill_next;
      // registered ready: stays honest because it looks at next fill
      in_ready <= (fill_next < DEPTH[AW:0]);
    end
  end
endmodule // sfa_stage_fifo

module sfa_sample_fifo #(
  parameter [6:0] DEV_ADDR  = 7'h40, // arbitrary bus address
  parameter       RAW_W     = 19,
  parameter       CHANNELS  = 4
) (
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire             scl_in,
  input  wire             sda_in,
  output reg              sda_out,
  output reg              sda_oe,
  input  wire             raw_valid,
  output wire             raw_ready,
  input  wire [RAW_W-1:0] raw_data,
  input  wire [1:0]       raw_channel,
  input  wire             raw_last,
  input  wire             ambient_overflow,
  input  wire             sense_start,
  input  wire             proximity_trigger,
  input  wire [1:0]       mode_select,
  input  wire [7:0]       pilot_drive_current,
  input  wire [7:0]       first_emitter_setting,
  output reg              proximity_mode,
  output reg  [1:0]       operating_mode,
  output reg  [7:0]       first_emitter_current,
  output reg              irq_n
);
  localparam SW = 24;
  localparam AC = RAW_W + 5;
  localparam [3:0] S_IDLE = 4'h0, S_ADDR = 4'h1, S_AACK = 4'h2, S_REG = 4'h3, S_RACKW = 4'h4,
                   S_WDATA = 4'h5, S_WACK = 4'h6, S_RDATA = 4'h7, S_MACK = 4'h8;

  function [2:0] avg_shift;
    input [2:0] code;
    avg_shift = (code > `SFA_AVG_MAX_SHIFT) ? `SFA_AVG_MAX_SHIFT : code;
  endfunction

  // registers
  reg  [3:0]    int_enable_reg;
  reg  [2:0]    avg_code_reg;
  reg           rollover_reg;
  reg  [3:0]    threshold_reg;
  reg  [4:0]    write_pointer_reg;
  reg  [4:0]    read_pointer_reg;
  reg  [5:0]    count_reg;
  reg  [4:0]    lost_sample_counter_reg;
  reg  [1:0]    byte_idx_reg;
  reg           almost_full_flag, sample_ready_flag, ambient_overflow_flag, proximity_flag;
  reg  [SW-1:0] sample_mem [0:31];
  reg  [AC-1:0] acc_mem [0:CHANNELS-1];
  reg  [4:0]    frame_cnt_reg;

  // serial port state
  reg           scl_q, sda_q;
  reg  [3:0]    state_reg;
  reg  [3:0]    bit_cnt_reg;
  reg  [7:0]    shift_reg;
  reg  [7:0]    ptr_reg;
  reg           rw_reg;
  reg           rd_strobe, wr_strobe;
  reg  [7:0]    rd_byte;

  wire scl_rise = scl_in && !scl_q;
  wire scl_fall = !scl_in && scl_q;
  wire start_c  = scl_in && scl_q && sda_q && !sda_in;
  wire stop_c   = scl_in && scl_q && !sda_q && sda_in;

  // averaging front end
  wire [2:0]    shift_n    = avg_shift(avg_code_reg);
  wire [4:0]    frames_m1  = (5'h01 << shift_n) - 5'h01;
  wire          raw_take   = raw_valid && raw_ready;
  wire [AC-1:0] acc_base   = (frame_cnt_reg == 5'h00) ? {AC{1'b0}} : acc_mem[raw_channel];
  wire [AC-1:0] acc_sum    = acc_base + {5'h00, raw_data};
  wire [AC-1:0] avg_val    = acc_sum >> shift_n;
  wire          avg_done   = (frame_cnt_reg == frames_m1);
  wire          st_valid;
  wire [SW-1:0] st_data;
  wire          flush      = proximity_trigger && proximity_mode;
  wire          host_busy  = (byte_idx_reg != 2'h0) || rd_strobe || wr_strobe || flush;
  wire          push       = st_valid && !host_busy;
  wire          fifo_full  = (count_reg == `SFA_FIFO_DEPTH);
  wire          force_roll = rollover_reg || proximity_mode;
  wire          pop_sel    = rd_strobe && (ptr_reg == `SFA_OFS_POP_DATA);
  wire          pop        = pop_sel && (count_reg != 6'h00)
                             && (byte_idx_reg == `SFA_BYTES_PER_SAMPLE - 2'h1);
  wire [5:0]    af_level   = `SFA_FIFO_DEPTH - {2'b00, threshold_reg};
  wire          status_rd  = rd_strobe && (ptr_reg == `SFA_OFS_STATUS);
  wire          data_rd    = pop_sel;

  sfa_stage_fifo #(.WIDTH(SW), .DEPTH(`SFA_STAGE_DEPTH)) u_stage (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (raw_valid && avg_done),
    .in_ready  (raw_ready),
    .in_data   (avg_val[SW-1:0]),
    .out_valid (st_valid),
    .out_ready (!host_busy),
    .out_data  (st_data)
  );

  // channel accumulators, one per emitter, pushed as each finishes
  always @(posedge clk_sys) begin
    if (raw_take)
      acc_mem[raw_channel] <= acc_sum;
  end

  always @(posedge clk_sys) begin
    if (!rstn)
      frame_cnt_reg <= 5'h00;
    else if (raw_take && raw_last)
      frame_cnt_reg <= avg_done ? 5'h00 : frame_cnt_reg + 5'h01;
  end

  always @(posedge clk_sys) begin
    if (push && (!fifo_full || force_roll))
      sample_mem[write_pointer_reg] <= st_data;
  end

  // read data mux with byte select
  wire [SW-1:0] head_sample = sample_mem[read_pointer_reg];
  always @* begin
    case (ptr_reg)
      `SFA_OFS_STATUS:      rd_byte = {almost_full_flag, sample_ready_flag, ambient_overflow_flag,
                                       proximity_flag, 4'h0};
      `SFA_OFS_INT_ENABLE:  rd_byte = {int_enable_reg, 4'h0};
      `SFA_OFS_WRITE_PTR:   rd_byte = {3'h0, write_pointer_reg};
      `SFA_OFS_LOST_COUNT:  rd_byte = {3'h0, lost_sample_counter_reg};
      `SFA_OFS_READ_PTR:    rd_byte = {3'h0, read_pointer_reg};
      `SFA_OFS_POP_DATA: begin
        if (count_reg == 6'h00)
          rd_byte = 8'h00;
        else if (byte_idx_reg == 2'h0)
          rd_byte = head_sample[23:16];
        else if (byte_idx_reg == 2'h1)
          rd_byte = head_sample[15:8];
        else
          rd_byte = head_sample[7:0];
      end
      `SFA_OFS_FIFO_CONFIG: rd_byte = {avg_code_reg, rollover_reg, threshold_reg};
      default:              rd_byte = 8'h00;
    endcase
  end

  // two-wire serial slave
  always @(posedge clk_sys) begin
    if (!rstn) begin
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
      state_reg   <= S_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      sda_oe      <= 1'b0;
      sda_out     <= 1'b0;
      rd_strobe   <= 1'b0;
      wr_strobe   <= 1'b0;
    end else begin
      scl_q     <= scl_in;
      sda_q     <= sda_in;
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
      // register pointer moves after each access; data register stays put for burst pops
      if ((rd_strobe || wr_strobe) && ptr_reg != `SFA_OFS_POP_DATA)
        ptr_reg <= ptr_reg + 8'h01;
      if (start_c) begin
        state_reg   <= S_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe      <= 1'b0;
      end else if (stop_c) begin
        state_reg <= S_IDLE;
        sda_oe    <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == S_ADDR || state_reg == S_REG || state_reg == S_WDATA) begin
          shift_reg   <= {shift_reg[6:0], sda_in};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (state_reg == S_RDATA) begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (state_reg == S_MACK) begin
          rw_reg <= sda_in; // nack from master ends the read
        end
      end else if (scl_fall) begin
        case (state_reg)
          S_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                rw_reg    <= shift_reg[0];
                sda_oe    <= 1'b1;
                state_reg <= S_AACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              rd_strobe <= 1'b1;
              shift_reg <= rd_byte;
              sda_oe    <= !rd_byte[7];
              state_reg <= S_RDATA;
            end else begin
              sda_oe    <= 1'b0;
              state_reg <= S_REG;
            end
          end
          S_REG: begin
            if (bit_cnt_reg == 4'h8) begin
              ptr_reg   <= shift_reg;
              sda_oe    <= 1'b1;
              state_reg <= S_RACKW;
            end
          end
          S_RACKW, S_WACK: begin
            bit_cnt_reg <= 4'h0;
            sda_oe      <= 1'b0;
            state_reg   <= S_WDATA;
          end
          S_WDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              wr_strobe <= 1'b1;
              sda_oe    <= 1'b1;
              state_reg <= S_WACK;
            end
          end
          S_RDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe    <= 1'b0;
              state_reg <= S_MACK;
            end else begin
              sda_oe    <= !shift_reg[3'h7 - bit_cnt_reg[2:0]];
            end
          end
          S_MACK: begin
            if (rw_reg) begin
              state_reg <= S_IDLE;
            end else begin
              bit_cnt_reg <= 4'h0;
              rd_strobe   <= 1'b1;
              shift_reg   <= rd_byte;
              sda_oe      <= !rd_byte[7];
              state_reg   <= S_RDATA;
            end
          end
          S_IDLE:  sda_oe <= 1'b0;
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // register writes, FIFO pointers and flags
  always @(posedge clk_sys) begin
    if (!rstn) begin
      int_enable_reg          <= `SFA_RST_INT_ENABLE;
      avg_code_reg            <= `SFA_RST_AVG_CODE;
      rollover_reg            <= `SFA_RST_ROLLOVER;
      threshold_reg           <= `SFA_RST_THRESHOLD;
      write_pointer_reg       <= 5'h00;
      read_pointer_reg        <= 5'h00;
      count_reg               <= 6'h00;
      lost_sample_counter_reg <= 5'h00;
      byte_idx_reg            <= 2'h0;
      almost_full_flag        <= 1'b0;
      sample_ready_flag       <= 1'b0;
      ambient_overflow_flag   <= 1'b0;
      proximity_flag          <= 1'b0;
      irq_n                   <= 1'b1;
    end else begin
      if (wr_strobe) begin
        case (ptr_reg)
          `SFA_OFS_INT_ENABLE: int_enable_reg <= shift_reg[7:4];
          `SFA_OFS_READ_PTR: begin
            read_pointer_reg <= shift_reg[4:0];
            count_reg        <= {1'b0, write_pointer_reg - shift_reg[4:0]};
            byte_idx_reg     <= 2'h0;
          end
          `SFA_OFS_FIFO_CONFIG: begin
            avg_code_reg  <= shift_reg[`SFA_CFG_AVG_HI:`SFA_CFG_AVG_LO];
            rollover_reg  <= shift_reg[`SFA_CFG_ROLLOVER];
            threshold_reg <= shift_reg[`SFA_CFG_THR_HI:`SFA_CFG_THR_LO];
          end
          default: ;
        endcase
      end
      // clears first, sets after: a set in the same cycle wins
      if (status_rd) begin
        almost_full_flag      <= 1'b0;
        ambient_overflow_flag <= 1'b0;
        proximity_flag        <= 1'b0;
      end
      if (status_rd || data_rd)
        sample_ready_flag <= 1'b0;
      if (ambient_overflow)
        ambient_overflow_flag <= 1'b1;
      if (pop_sel && count_reg != 6'h00)
        byte_idx_reg <= pop ? 2'h0 : byte_idx_reg + 2'h1;
      if (pop) begin
        read_pointer_reg        <= read_pointer_reg + 5'h01;
        count_reg               <= count_reg - 6'h01;
        lost_sample_counter_reg <= 5'h00;
      end
      // push never meets a pop or host write: drain is held while the host is mid-access
      if (flush) begin
        read_pointer_reg        <= write_pointer_reg;
        count_reg               <= 6'h00;
        byte_idx_reg            <= 2'h0;
        lost_sample_counter_reg <= 5'h00;
        proximity_flag          <= 1'b1;
      end else if (push) begin
        if (fifo_full && lost_sample_counter_reg != `SFA_LOST_MAX)
          lost_sample_counter_reg <= lost_sample_counter_reg + 5'h01;
        if (!fifo_full) begin
          write_pointer_reg <= write_pointer_reg + 5'h01;
          count_reg         <= count_reg + 6'h01;
          sample_ready_flag <= 1'b1;
          if (count_reg + 6'h01 >= af_level)
            almost_full_flag <= 1'b1;
        end else if (force_roll) begin
          write_pointer_reg <= write_pointer_reg + 5'h01;
          read_pointer_reg  <= read_pointer_reg + 5'h01;
          sample_ready_flag <= 1'b1;
          almost_full_flag  <= 1'b1;
        end
        // stop-on-full: sample dropped, pointers held
      end
      irq_n <= !((almost_full_flag && int_enable_reg[3])
              || (sample_ready_flag && int_enable_reg[2])
              || (ambient_overflow_flag && int_enable_reg[1])
              || (proximity_flag && int_enable_reg[0]));
    end
  end

  // sensing mode sequencing
  always @(posedge clk_sys) begin
    if (!rstn) begin
      proximity_mode        <= 1'b0;
      operating_mode        <= 2'h0;
      first_emitter_current <= 8'h00;
    end else if (sense_start) begin
      if (int_enable_reg[0]) begin
        proximity_mode        <= 1'b1;
        operating_mode        <= 2'h0;
        first_emitter_current <= pilot_drive_current;
      end else begin
        proximity_mode        <= 1'b0;
        operating_mode        <= mode_select;
        first_emitter_current <= first_emitter_setting;
      end
    end else if (flush) begin
      proximity_mode        <= 1'b0;
      operating_mode        <= mode_select;
      first_emitter_current <= first_emitter_setting;
    end
  end
endmodule // sfa_sample_fifo
`default_nettype wire

/* testbench/sfa_fifo_checker.sv */
// Purpose: port assertions for the sample FIFO block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every sfa_sample_fifo instance
`timescale 1ns/1ps
`default_nettype none
module sfa_fifo_checker (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       scl_in,
  input wire logic       sda_oe,
  input wire logic       sense_start,
  input wire logic       proximity_trigger,
  input wire logic [1:0] mode_select,
  input wire logic [7:0] pilot_drive_current,
  input wire logic       proximity_mode,
  input wire logic [1:0] operating_mode,
  input wire logic [7:0] first_emitter_current,
  input wire logic       irq_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  irq_after_reset_a: assert property ($rose(rstn) |-> irq_n)
    else $error("irq_n low right after reset");
  prox_mode_idle_a: assert property (proximity_mode |-> operating_mode == 2'h0)
    else $error("operating mode set during proximity mode");
  prox_needs_start_a: assert property ($rose(proximity_mode) |-> $past(sense_start))
    else $error("proximity mode entered without start");
  prox_exit_a: assert property (proximity_mode && proximity_trigger |=>
    !proximity_mode && operating_mode == $past(mode_select))
    else $error("trigger did not switch to selected mode");
  trig_ignored_a: assert property (!proximity_mode && proximity_trigger && !sense_start |=>
    !proximity_mode && $stable(operating_mode))
    else $error("trigger acted outside proximity mode");
  pilot_drive_a: assert property (proximity_mode && $past(proximity_mode) &&
    $stable(pilot_drive_current) |-> first_emitter_current == pilot_drive_current)
    else $error("first emitter not at pilot current");
  // data may only change while the clock line is low
  ack_scl_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("device pulled sda while scl high");
  sda_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda changed while scl high");

  cover property ($fell(proximity_mode));
  cover property ($fell(irq_n));
  cover property ($rose(sda_oe));
endmodule // sfa_fifo_checker

bind sfa_sample_fifo sfa_fifo_checker chk (
  .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl_in), .sda_oe(sda_oe), .sense_start(sense_start),
  .proximity_trigger(proximity_trigger), .mode_select(mode_select),
  .pilot_drive_current(pilot_drive_current), .proximity_mode(proximity_mode),
  .operating_mode(operating_mode), .first_emitter_current(first_emitter_current), .irq_n(irq_n)
);
`default_nettype wire

/* testbench/sfa_host_model.sv */
// Purpose: behavioural host processor on the two-wire serial port
// Assumes: open-drain line with pull-up; device pulls low through its enable
// Notes:   each read byte shows as a one-cycle rd_valid pulse
`timescale 1ns/1ps
`default_nettype none
module sfa_host_model #(
  parameter HALF = 5
) (
  input  wire logic       clk_sys,
  input  wire logic       dev_oe,
  output var  logic       scl,
  output wire logic       sda,
  output var  logic       rd_valid,
  output var  logic [7:0] rd_data
);
  logic pull = 1'b0;
  // released line floats up through the pull-up
  assign sda = ~(pull | dev_oe);
  initial begin
    scl = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    pull = ~b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    r = sda;
    scl = 1'b0;
    tick(1);
  endtask
  task automatic start_c;
    pull = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    pull = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic stop_c;
    pull = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    pull = 1'b0;
    tick(HALF);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    k1 = 1'b0;
    k2 = 1'b0;
    start_c;
    send({dev, 1'b0}, k0);
    if (k0) begin
      send(a, k1);
      send(d, k2);
    end
    stop_c;
    ok = k0 & k1 & k2;
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, input int n);
    logic k;
    logic [7:0] v;
    start_c;
    send({dev, 1'b0}, k);
    send(a, k);
    start_c;
    send({dev, 1'b1}, k);
    for (int j = 0; j < n; j++) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
      // no acknowledge on the last byte ends the read
      bit_io(j == n - 1, k);
      rd_data = v;
      rd_valid = 1'b1;
      tick(1);
      rd_valid = 1'b0;
    end
    stop_c;
  endtask
endmodule // sfa_host_model
`default_nettype wire

/* testbench/sfa_sample_fifo_tb_top.sv */
// Purpose: self-checking bench for the sample FIFO block
// Assumes: host model on the serial port, raw stream driven here
// Notes:   read bytes are checked in order against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module sfa_sample_fifo_tb_top;
  localparam logic [6:0] DEV = 7'h40;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        raw_valid, raw_ready, raw_last, ambient_overflow, sense_start, proximity_trigger;
  logic [18:0] raw_data;
  logic [1:0]  raw_channel, mode_select, operating_mode;
  logic [7:0]  pilot_drive_current, first_emitter_setting, first_emitter_current, rd_data;
  logic        sda_out, sda_oe, proximity_mode, irq_n, scl, sda, rd_valid;
  logic [7:0]  exp_q[$];
  logic [18:0] vals[$];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          seed = 32'h611c4b33;

  always #12.5 clk_sys = ~clk_sys;

  sfa_sample_fifo uut (
    .clk_sys(clk_sys), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_data(raw_data), .raw_channel(raw_channel),
    .raw_last(raw_last), .ambient_overflow(ambient_overflow), .sense_start(sense_start),
    .proximity_trigger(proximity_trigger), .mode_select(mode_select),
    .pilot_drive_current(pilot_drive_current), .first_emitter_setting(first_emitter_setting),
    .proximity_mode(proximity_mode), .operating_mode(operating_mode),
    .first_emitter_current(first_emitter_current), .irq_n(irq_n)
  );
  sfa_host_model host (
    .clk_sys(clk_sys), .dev_oe(sda_oe), .scl(scl), .sda(sda), .rd_valid(rd_valid), .rd_data(rd_data)
  );

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd_n(input logic [7:0] a, input logic [23:0] e, input int n);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(e[8*i +: 8]);
    host.read_reg(DEV, a, n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_n(a, {16'h0, e}, 1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.write_reg(DEV, a, d, ok);
  endtask
  // valid stays up between pushes; the caller drops it after a batch
  task automatic push(input logic [1:0] ch, input logic lst, input logic [18:0] d);
    int n = 0;
    raw_channel = ch;
    raw_last = lst;
    raw_data = d;
    raw_valid = 1'b1;
    while (raw_ready !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    step(1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(3);
  endtask

  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1) chk("read byte", 24'(rd_data), exp_q.size() ? 24'(exp_q.pop_front()) : 24'hffffff);
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    print_verdict;
  end

  initial begin
    logic [31:0] d, s0, s1;
    logic ok;
    int nf, sh;
    {raw_valid, raw_last, ambient_overflow, sense_start, proximity_trigger} = 5'h0;
    raw_data = 19'h0;
    raw_channel = 2'h0;
    mode_select = 2'h2;
    pilot_drive_current = 8'h3c;
    first_emitter_setting = 8'h55;
    step(2);
    rstn = 1'b1;
    step(2);
    rd(8'h02, 8'h00);
    rd(8'h08, 8'h0f);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    wr(8'h04, 8'h1f);
    rd(8'h04, 8'h00);
    wr(8'h02, 8'h40);
    for (int c = 0; c < 8; c++) begin
      sh = c > 5 ? 5 : c;
      nf = 1 << sh;
      wr(8'h08, {c[2:0], 5'h0f});
      s0 = 32'h0;
      s1 = 32'h0;
      for (int f = 0; f < nf; f++) begin
        d = $random(seed);
        push(2'h0, 1'b0, d[18:0]);
        s0 = s0 + d[18:0];
        d = $random(seed);
        push(2'h1, 1'b1, d[18:0]);
        s1 = s1 + d[18:0];
      end
      raw_valid = 1'b0;
      step(12);
      chk("irq_n", 24'(irq_n), 24'h0);
      rd_n(8'h07, 24'(s0 >> sh), 3);
      rd_n(8'h07, 24'(s1 >> sh), 3);
      chk("irq_n", 24'(irq_n), 24'h1);
      rd(8'h04, 8'(2 * c + 2));
    end
    // stop on full: 34 pushes into an empty store with pointers at 16
    wr(8'h08, 8'h0f);
    wr(8'h02, 8'h80);
    for (int i = 0; i < 37; i++) begin
      d = $random(seed);
      vals.push_back(d[18:0]);
    end
    for (int i = 0; i < 34; i++) push(2'h0, 1'b1, vals[i]);
    raw_valid = 1'b0;
    step(12);
    chk("irq_n", 24'(irq_n), 24'h0);
    rd(8'h04, 8'h10);
    rd(8'h05, 8'h02);
    rd(8'h00, 8'hc0);
    chk("irq_n", 24'(irq_n), 24'h1);
    rd(8'h00, 8'h00);
    rd_n(8'h07, {5'h0, vals[0]}, 3);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h11);
    rd_n(8'h07, {5'h0, vals[1]} >> 8, 2);
    rd(8'h06, 8'h11);
    rd(8'h07, vals[1][7:0]);
    rd(8'h06, 8'h12);
    host.write_reg(DEV, 8'h06, 8'h11, ok);
    chk("write ack", 24'(ok), 24'h1);
    rd_n(8'h07, {5'h0, vals[1]}, 3);
    // roll-over: count 30, three pushes overwrite the oldest once
    wr(8'h08, 8'h1f);
    for (int i = 34; i < 37; i++) push(2'h0, 1'b1, vals[i]);
    raw_valid = 1'b0;
    step(12);
    rd(8'h04, 8'h13);
    rd(8'h06, 8'h13);
    rd(8'h05, 8'h01);
    rd_n(8'h07, {5'h0, vals[3]}, 3);
    wr(8'h02, 8'h00);
    pulse(ambient_overflow);
    chk("irq_n", 24'(irq_n), 24'h1);
    wr(8'h02, 8'h20);
    chk("irq_n", 24'(irq_n), 24'h0);
    rd(8'h00, 8'ha0);
    chk("irq_n", 24'(irq_n), 24'h1);
    // proximity start with stop-on-full selected, store one short of full
    wr(8'h08, 8'h0f);
    wr(8'h02, 8'h10);
    pulse(sense_start);
    chk("proximity mode", 24'(proximity_mode), 24'h1);
    chk("emitter current", 24'(first_emitter_current), 24'h3c);
    chk("sda_out", 24'(sda_out), 24'h0);
    for (int i = 0; i < 2; i++) push(2'h0, 1'b1, vals[i]);
    raw_valid = 1'b0;
    step(12);
    rd(8'h06, 8'h15);
    pulse(proximity_trigger);
    chk("proximity mode", 24'(proximity_mode), 24'h0);
    chk("operating mode", 24'(operating_mode), 24'h2);
    chk("irq_n", 24'(irq_n), 24'h0);
    rd(8'h00, 8'hd0);
    pulse(proximity_trigger);
    rd(8'h06, 8'h15);
    rd(8'h07, 8'h00);
    print_verdict;
  end
endmodule // sfa_sample_fifo_tb_top
`default_nettype wire
